/* File: src/rhpc_pkg.sv */
// package: constants and carriers for the run/halt and phase control block
package rhpc_pkg;

  // apb register map
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register fields
  localparam int CTRL_AUTO_RESTART_BIT = 0;
  localparam int CTRL_PARITY_HALT_BIT  = 1;
  localparam int CTRL_PROTECT_EN_BIT   = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h0;

  // status register fields
  localparam int STAT_RUN_BIT          = 0;
  localparam int STAT_RUN_HALT_BIT     = 1;
  localparam int STAT_SINGLE_INSTR_BIT = 2;
  localparam int STAT_SINGLE_CYCLE_BIT = 3;
  localparam int STAT_DISPLAY_HALT_BIT = 4;
  localparam int STAT_PANEL_EN_BIT     = 5;
  localparam int STAT_PHASE_LSB        = 8;

  // mode flop reset values
  localparam logic RUN_RESET          = 1'b0;
  localparam logic RUN_HALT_RESET     = 1'b0;
  localparam logic SINGLE_INSTR_RESET = 1'b0;
  localparam logic SINGLE_CYCLE_RESET = 1'b0;
  localparam logic DISPLAY_HALT_RESET = 1'b1;

  // number of panel and power pins passing the synchroniser
  localparam int PIN_COUNT = 9;

  // panel and power pins, all asynchronous to clock
  typedef struct packed {
    logic run_request;
    logic single_instr_request;
    logic single_cycle_request;
    logic halt_switch;
    logic misc_switch;
    logic panel_preset;
    logic pc_switch;
    logic power_on_normal;
    logic restart_pulse;
  } rhpc_pins_s;

  // microcode and instruction decodes, same clock
  typedef struct packed {
    logic first_clock_phase;
    logic end_of_phase;
    logic conditional_halt_microcode;
    logic force_fetch_microcode;
    logic user_halt;
    logic parity_error;
    logic power_fail;
    logic interrupt_pending;
    logic memory_ref_instr;
    logic instr_indirect;
    logic operand_indirect;
    logic jump_instruction;
    logic subroutine_call_instruction;
    logic protect_violation_interrupt;
    logic third_indirect;
  } rhpc_ucode_s;

  // the four phase flops
  typedef struct packed {
    logic normal_fetch_flop;
    logic interrupt_fetch_flop;
    logic indirect_phase_flop;
    logic execute_phase_flop;
  } rhpc_phase_s;

  localparam rhpc_phase_s PHASE_FETCH = 4'h8;
  localparam rhpc_phase_s PHASE_INTF  = 4'h4;
  localparam rhpc_phase_s PHASE_IND   = 4'h2;
  localparam rhpc_phase_s PHASE_EXEC  = 4'h1;

endpackage

/* File: src/rhpc_step_gen.sv */
// module: pin synchroniser and single-clock step pulse generator
`timescale 1ns/1ns
module rhpc_step_gen (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire rhpc_pkg::rhpc_pins_s pins,
  input  wire logic               auto_restart,
  output rhpc_pkg::rhpc_pins_s    pins_sync,
  output logic                    step
);

  logic [rhpc_pkg::PIN_COUNT-1:0] meta;
  logic [rhpc_pkg::PIN_COUNT-1:0] stable;
  logic                           step_flop_a;
  logic                           step_flop_b;
  logic                           next_step_flop_a;
  rhpc_pkg::rhpc_pins_s           s;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser, first stage read only by the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta   <= '0;
      stable <= '0;
    end else begin
      meta   <= pins;
      stable <= meta;
    end
  end

  assign s         = stable;
  assign pins_sync = s;

  ////////////////////////////////////////////////////////////////////////
  // any mode or misc switch, or restart with auto restart selected
  always_comb begin
    next_step_flop_a = s.run_request | s.single_instr_request
                     | s.single_cycle_request | s.halt_switch
                     | s.misc_switch
                     | (s.restart_pulse & auto_restart);
  end

  // flop a follows the request, flop b one clock later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step_flop_a <= 1'b0;
      step_flop_b <= 1'b0;
    end else begin
      step_flop_a <= next_step_flop_a;
      step_flop_b <= step_flop_a;
    end
  end

  // exactly one clock high per press
  assign step = step_flop_a & ~step_flop_b;

endmodule

/* File: src/rhpc_control.sv */
// module: run/halt mode and machine phase control with apb registers
`timescale 1ns/1ns
//
// Behaviour
// - step generator gives one-clock pulse per mode or misc panel switch press.
// - step pulse also given on power return when auto restart is selected.
// - run request, step, not run-halt set run-halt and run, clear display-halt.
// - panel enable follows display-halt; low disables most panel switches.
// - single-instruction request with step sets single-instr and run, clears halt.
// - single-instr end-of-phase in execute clears run; display-halt one clock later.
// - run low forces rom enable and address increment low.
// - single-cycle request with step sets single-cycle and run, clears halt.
// - single-cycle ends on end-of-phase or conditional halt; halt one clock later.
// - halt switch while run-halt is set, user halt, parity halt or power fail without auto restart raise halt request.
// - user halt acts only while memory protect is disabled.
// - with run-halt clear, next end-of-phase clears run; halt one clock later.
// - restart pulse with step and not run-halt enters run mode.
// - phase flops step to the mapper target only on end-of-phase with first clock phase.
// - interrupt-fetch, indirect and execute set signals go to rom mapper.
// - normal fetch entered from execute absent interrupt conditions, or when forced.
// - interrupt fetch reached from fetch, indirect, execute or auto restart.
// - fetch goes to interrupt fetch on interrupt, non-jump memory ref.
// - indirect goes to interrupt fetch on interrupt unless indirect jump/call.
// - execute goes to interrupt fetch on interrupt per prior indirect kind.
// - preset, pc switch in halt, force-fetch or power-on force normal fetch.
// - indirect goes to execute when operand direct and no interrupt or jump.
module rhpc_control (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // panel and power pins
  input  wire rhpc_pkg::rhpc_pins_s  pins,
  // decoder inputs
  input  wire rhpc_pkg::rhpc_ucode_s ucode,
  // outputs to rom control, mapper and i/o slots
  output logic                       run,
  output logic                       panel_enable,
  output logic                       rom_enable,
  output logic                       rom_addr_increment,
  output logic                       halt_request,
  output logic                       step_pulse,
  output rhpc_pkg::rhpc_phase_s      phase,
  output logic                       set_interrupt_fetch,
  output logic                       set_indirect_phase,
  output logic                       set_execute_phase
);

  rhpc_pkg::rhpc_pins_s  ps;
  logic                  step;
  logic [2:0]            ctrl;
  logic [2:0]            next_ctrl;
  logic                  auto_restart;
  logic                  parity_halt;
  logic                  protect_en;

  logic run_halt_flop;
  logic single_instr_flop;
  logic single_cycle_flop;
  logic display_halt_flop;
  logic halt_pending;
  logic next_run;
  logic next_run_halt;
  logic next_single_instr;
  logic next_single_cycle;
  logic next_display_halt;
  logic next_halt_pending;
  logic arm;
  logic stop_now;
  logic restart_entry;
  logic run_req;
  logic si_req;
  logic sc_req;

  rhpc_pkg::rhpc_phase_s next_phase;
  rhpc_pkg::rhpc_phase_s target;
  logic                  jump_or_call;
  logic                  force_fetch;
  logic                  phase_clock;
  logic                  eop;

  logic                  apb_access;
  logic                  addr_ok;
  logic [31:0]           next_prdata;
  logic                  next_pslverr;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and step generator
  rhpc_step_gen u_step (
    .clock        (clock),
    .rst_n        (rst_n),
    .pins         (pins),
    .auto_restart (auto_restart),
    .pins_sync    (ps),
    .step         (step)
  );

  assign step_pulse   = step;
  assign auto_restart = ctrl[rhpc_pkg::CTRL_AUTO_RESTART_BIT];
  assign parity_halt  = ctrl[rhpc_pkg::CTRL_PARITY_HALT_BIT];
  assign protect_en   = ctrl[rhpc_pkg::CTRL_PROTECT_EN_BIT];
  assign eop          = ucode.end_of_phase;

  ////////////////////////////////////////////////////////////////////////
  // halt request sources
  always_comb begin
    halt_request = (ps.halt_switch & run_halt_flop)
                 | (ucode.user_halt & ~protect_en)
                 | (ucode.parity_error & parity_halt)
                 | (ucode.power_fail & ~auto_restart);
  end

  ////////////////////////////////////////////////////////////////////////
  // mode switches count only while the panel is enabled; the halt
  // action of halt/cycle and the restart pulse stay live in run
  always_comb begin
    run_req = ps.run_request & display_halt_flop;
    si_req  = ps.single_instr_request & display_halt_flop;
    sc_req  = ps.single_cycle_request & display_halt_flop;
  end

  ////////////////////////////////////////////////////////////////////////
  // mode flops next state
  always_comb begin
    arm               = step & ~run_halt_flop;
    restart_entry     = ps.restart_pulse & arm & ~single_instr_flop
                      & ~single_cycle_flop;
    stop_now          = 1'b0;
    next_run          = run;
    next_run_halt     = run_halt_flop;
    next_single_instr = single_instr_flop;
    next_single_cycle = single_cycle_flop;
    next_display_halt = display_halt_flop;
    next_halt_pending = 1'b0;
    // display-halt sets one clock after run drops
    if (halt_pending) begin
      next_display_halt = 1'b1;
    end
    if (run) begin
      if (single_instr_flop & eop & phase.execute_phase_flop) begin
        stop_now          = 1'b1;
        next_single_instr = 1'b0;
      end
      if (single_cycle_flop
          & (eop | ucode.conditional_halt_microcode)) begin
        stop_now          = 1'b1;
        next_single_cycle = 1'b0;
      end
      if (~run_halt_flop & ~single_instr_flop & ~single_cycle_flop
          & eop) begin
        stop_now = 1'b1;
      end
    end
    if (stop_now) begin
      next_run          = 1'b0;
      next_halt_pending = 1'b1;
    end
    if (halt_request) begin
      next_run_halt = 1'b0;
    end
    if (arm & (run_req | restart_entry)) begin
      next_run_halt     = 1'b1;
      next_run          = 1'b1;
      next_display_halt = 1'b0;
      next_halt_pending = 1'b0;
    end else if (arm & si_req) begin
      next_single_instr = 1'b1;
      next_run          = 1'b1;
      next_display_halt = 1'b0;
      next_halt_pending = 1'b0;
    end else if (arm & sc_req) begin
      next_single_cycle = 1'b1;
      next_run          = 1'b1;
      next_display_halt = 1'b0;
      next_halt_pending = 1'b0;
    end
  end

  // mode flops, reset into halt with panel enabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run               <= rhpc_pkg::RUN_RESET;
      run_halt_flop     <= rhpc_pkg::RUN_HALT_RESET;
      single_instr_flop <= rhpc_pkg::SINGLE_INSTR_RESET;
      single_cycle_flop <= rhpc_pkg::SINGLE_CYCLE_RESET;
      display_halt_flop <= rhpc_pkg::DISPLAY_HALT_RESET;
      halt_pending      <= 1'b0;
    end else begin
      run               <= next_run;
      run_halt_flop     <= next_run_halt;
      single_instr_flop <= next_single_instr;
      single_cycle_flop <= next_single_cycle;
      display_halt_flop <= next_display_halt;
      halt_pending      <= next_halt_pending;
    end
  end

  // panel and rom gating
  assign panel_enable       = display_halt_flop;
  assign rom_enable         = run;
  assign rom_addr_increment = run;

  ////////////////////////////////////////////////////////////////////////
  // phase target decode for the rom mapper
  always_comb begin
    jump_or_call = ucode.jump_instruction
                 | ucode.subroutine_call_instruction;
    target       = rhpc_pkg::PHASE_EXEC;
    unique case (1'b1)
      phase.normal_fetch_flop: begin
        if (ucode.interrupt_pending & ucode.memory_ref_instr
            & ~ucode.jump_instruction
            & (~(ucode.subroutine_call_instruction
                 & ucode.instr_indirect)
               | ucode.protect_violation_interrupt)) begin
          target = rhpc_pkg::PHASE_INTF;
        end else if (ucode.memory_ref_instr & ucode.instr_indirect
                     & ~ucode.protect_violation_interrupt
                     & (~ucode.interrupt_pending | jump_or_call)) begin
          target = rhpc_pkg::PHASE_IND;
        end
      end
      phase.interrupt_fetch_flop: begin
        if (ucode.memory_ref_instr & ucode.instr_indirect
            & ~ucode.protect_violation_interrupt) begin
          target = rhpc_pkg::PHASE_IND;
        end
      end
      phase.indirect_phase_flop: begin
        if (ucode.interrupt_pending
            & (~jump_or_call
               | (ucode.operand_indirect & ucode.third_indirect))) begin
          target = rhpc_pkg::PHASE_INTF;
        end else if (ucode.operand_indirect) begin
          target = rhpc_pkg::PHASE_IND;
        end else begin
          target = rhpc_pkg::PHASE_EXEC;
        end
      end
      phase.execute_phase_flop: begin
        if (ucode.interrupt_pending
            & (~(ucode.instr_indirect & jump_or_call)
               | ucode.protect_violation_interrupt
               | ucode.third_indirect)) begin
          target = rhpc_pkg::PHASE_INTF;
        end else begin
          target = rhpc_pkg::PHASE_FETCH;
        end
      end
      default: begin
        target = rhpc_pkg::PHASE_FETCH;
      end
    endcase
  end

  // set-phase lines to the mapper
  assign set_interrupt_fetch = target.interrupt_fetch_flop;
  assign set_indirect_phase  = target.indirect_phase_flop;
  assign set_execute_phase   = target.execute_phase_flop;

  ////////////////////////////////////////////////////////////////////////
  // phase flops next state
  always_comb begin
    force_fetch = ps.panel_preset & display_halt_flop
                | ps.pc_switch & display_halt_flop
                | ucode.force_fetch_microcode
                | ~ps.power_on_normal;
    phase_clock = eop & ucode.first_clock_phase;
    next_phase  = phase;
    if (force_fetch) begin
      next_phase = rhpc_pkg::PHASE_FETCH;
    end else if (restart_entry & auto_restart) begin
      next_phase = rhpc_pkg::PHASE_INTF;
    end else if (phase_clock) begin
      next_phase = target;
    end
  end

  // phase flops, reset into normal fetch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= rhpc_pkg::PHASE_FETCH;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states, error on unmapped address
  always_comb begin
    apb_access   = psel & penable;
    addr_ok      = (paddr == rhpc_pkg::CTRL_OFFSET)
                 | (paddr == rhpc_pkg::STATUS_OFFSET);
    next_ctrl    = ctrl;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel & ~penable) begin
      next_pslverr = ~addr_ok;
      if (~pwrite & (paddr == rhpc_pkg::CTRL_OFFSET)) begin
        next_prdata[2:0] = ctrl;
      end else if (~pwrite & (paddr == rhpc_pkg::STATUS_OFFSET)) begin
        next_prdata[rhpc_pkg::STAT_RUN_BIT]          = run;
        next_prdata[rhpc_pkg::STAT_RUN_HALT_BIT]     = run_halt_flop;
        next_prdata[rhpc_pkg::STAT_SINGLE_INSTR_BIT] = single_instr_flop;
        next_prdata[rhpc_pkg::STAT_SINGLE_CYCLE_BIT] = single_cycle_flop;
        next_prdata[rhpc_pkg::STAT_DISPLAY_HALT_BIT] = display_halt_flop;
        next_prdata[rhpc_pkg::STAT_PANEL_EN_BIT]     = panel_enable;
        next_prdata[rhpc_pkg::STAT_PHASE_LSB +: 4]   = phase;
      end
    end else if (apb_access) begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
    if (apb_access & pwrite & (paddr == rhpc_pkg::CTRL_OFFSET)) begin
      next_ctrl = pwdata[2:0];
    end
  end

  // control register and registered read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= rhpc_pkg::CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = 1'b1;

endmodule

/* File: tb/rhpc_control_checker.sv */
// checker: concurrent assertions on the control block ports
`timescale 1ns/1ns
module rhpc_control_checker (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire rhpc_pkg::rhpc_ucode_s ucode,
  input wire logic                  run,
  input wire logic                  panel_enable,
  input wire logic                  rom_enable,
  input wire logic                  rom_addr_increment,
  input wire logic                  step_pulse,
  input wire rhpc_pkg::rhpc_phase_s phase,
  input wire logic                  set_interrupt_fetch,
  input wire logic                  set_indirect_phase,
  input wire logic                  set_execute_phase
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // phase clock enable and stop sequence
  logic eop1;
  assign eop1 = ucode.end_of_phase && ucode.first_clock_phase;
  sequence s_rearm;
    !run ##1 (panel_enable || run);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  step_one_a: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse longer than one clock");
  rom_gate_a: assert property (
    rom_enable == run && rom_addr_increment == run)
    else $error("rom controls do not follow run");
  run_start_a: assert property (
    $rose(run) |-> $past(step_pulse) && !panel_enable)
    else $error("run set without step or panel still enabled");
  halt_after_a: assert property ($fell(run) |-> s_rearm)
    else $error("display halt not set one clock after run drop");
  phase_hot_a: assert property ($onehot(phase))
    else $error("phase not one-hot");
  phase_hold_a: assert property ($changed(phase) |->
    $past(eop1) || phase == rhpc_pkg::PHASE_FETCH ||
    phase == rhpc_pkg::PHASE_INTF)
    else $error("phase moved without end of phase");
  exec_fetch_a: assert property (
    phase == rhpc_pkg::PHASE_EXEC && eop1 && !ucode.interrupt_pending &&
    !ucode.force_fetch_microcode |=> phase == rhpc_pkg::PHASE_FETCH)
    else $error("execute did not return to fetch");
  ind_exec_a: assert property (
    phase == rhpc_pkg::PHASE_IND && eop1 && !ucode.operand_indirect &&
    !ucode.interrupt_pending && !ucode.force_fetch_microcode
    |=> phase == rhpc_pkg::PHASE_EXEC)
    else $error("indirect did not go to execute");
  ind_set_a: assert property (
    phase == rhpc_pkg::PHASE_IND && !ucode.operand_indirect &&
    !ucode.interrupt_pending |-> set_execute_phase && !set_interrupt_fetch)
    else $error("wrong set phase from indirect");
  exec_intf_a: assert property (
    phase == rhpc_pkg::PHASE_EXEC && ucode.interrupt_pending &&
    !ucode.instr_indirect |-> set_interrupt_fetch)
    else $error("execute with interrupt not to interrupt fetch");
  fetch_intf_a: assert property (
    phase == rhpc_pkg::PHASE_FETCH && ucode.interrupt_pending &&
    ucode.memory_ref_instr && !ucode.jump_instruction &&
    !ucode.instr_indirect |-> set_interrupt_fetch)
    else $error("fetch with interrupt not to interrupt fetch");
endmodule

bind rhpc_control rhpc_control_checker chk (.clock, .rst_n, .ucode, .run,
  .panel_enable, .rom_enable, .rom_addr_increment, .step_pulse, .phase,
  .set_interrupt_fetch, .set_indirect_phase, .set_execute_phase);

/* File: tb/rhpc_panel_model.sv */
// model: operator panel switches and power pins
`timescale 1ns/1ns
module rhpc_panel_model (
  input wire logic             clock,
  output rhpc_pkg::rhpc_pins_s pins
);
  // power good from the start, every switch released
  initial pins = 9'h002;

  // press one switch, hold it, release and let the release settle
  task automatic press(input int idx, input int hold);
    @(posedge clock);
    pins[idx] <= 1'b1;
    repeat (hold) @(posedge clock);
    pins[idx] <= 1'b0;
    repeat (4) @(posedge clock); // released before any next press
  endtask
endmodule

/* File: tb/rhpc_control_tb.sv */
// testbench: self-checking bench for run/halt and phase control
`timescale 1ns/1ns
module rhpc_control_tb;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic [31:0]           rd;
  logic                  pready, pslverr, er, run, panel_enable;
  logic                  rom_enable, rom_addr_increment, halt_request;
  logic                  step_pulse, sif, sip, sep;
  rhpc_pkg::rhpc_pins_s  pins;
  rhpc_pkg::rhpc_ucode_s ucode = '0;
  rhpc_pkg::rhpc_phase_s phase;
  int                    miscompares = 0;
  int                    n_checks = 0;
  int                    cycles = 0;
  // phase walk: {fcp,eop,...} ucode words and the phase that follows
  logic [14:0] tu [9] = '{15'h2060, 15'h6060, 15'h6080, 15'h0800, 15'h6060,
                          15'h6000, 15'h6080, 15'h0800, 15'h60c0};
  logic [3:0]  te [9] = '{4'h8, 4'h2, 4'h4, 4'h8, 4'h2, 4'h1, 4'h4, 4'h8,
                          4'h4};

  always #10 clock = ~clock;

  rhpc_panel_model panel (.clock(clock), .pins(pins));

  rhpc_control DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .ucode(ucode), .run(run), .panel_enable(panel_enable),
    .rom_enable(rom_enable), .rom_addr_increment(rom_addr_increment),
    .halt_request(halt_request), .step_pulse(step_pulse), .phase(phase),
    .set_interrupt_fetch(sif), .set_indirect_phase(sip),
    .set_execute_phase(sep));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // apb master: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(input logic [31:0] exp);
    apb(1'b0, rhpc_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // mode entry, stop and halt causes
  task automatic start(input int idx);
    panel.press(idx, 6);
    @(negedge clock);
    chk(run, 1'b1);
    chk(panel_enable, 1'b0);
    chk(rom_addr_increment, 1'b1);
  endtask

  task automatic stop(input logic [14:0] u);
    @(posedge clock);
    ucode <= u;
    @(posedge clock);
    ucode <= '0;
    @(negedge clock);
    chk(run, 1'b0);
    chk(rom_enable, 1'b0);
    chk(panel_enable, 1'b0);
    @(negedge clock);
    chk(panel_enable, 1'b1);
  endtask

  task automatic cause(input logic [14:0] u, input logic exp);
    @(posedge clock);
    ucode <= u;
    @(negedge clock);
    chk(halt_request, exp);
    @(posedge clock);
    ucode <= '0;
  endtask

  task automatic walk(input int from, input int to);
    for (int i = from; i < to; i++) begin
      @(posedge clock);
      ucode <= tu[i];
      @(negedge clock);
      if (tu[i][14])
        chk({sif, sip, sep}, te[i][2:0]);
      @(posedge clock);
      ucode <= '0;
      @(negedge clock);
      chk(phase, te[i]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    @(negedge clock);
    chk(run, 1'b0);
    chk(panel_enable, 1'b1);
    chk(phase, rhpc_pkg::PHASE_FETCH);
    stat(32'h830);
    apb(1'b1, rhpc_pkg::STATUS_OFFSET, 32'hff);
    stat(32'h830);
    apb(1'b1, rhpc_pkg::CTRL_OFFSET, 32'h7);
    apb(1'b0, rhpc_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h7);
    chk(er, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic t_halt();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rhpc_pkg::CTRL_OFFSET, i == 2 ? 32'h2 : 32'h0);
      start(8);
      stat(32'h803);
      if (i == 1) begin
        apb(1'b1, rhpc_pkg::CTRL_OFFSET, 32'h4);
        cause(15'h0400, 1'b0);
        stat(32'h803);
        apb(1'b1, rhpc_pkg::CTRL_OFFSET, 32'h0);
      end
      if (i == 0)
        panel.press(5, 6);
      else
        cause(15'h0800 >> i, 1'b1);
      stat(32'h801);
      chk(run, 1'b1);
      stop(15'h2000);
    end
  endtask

  task automatic t_phase();
    walk(0, 9);
    panel.press(3, 6);
    chk(phase, rhpc_pkg::PHASE_FETCH);
    walk(1, 2);
    panel.press(2, 6);
    chk(phase, rhpc_pkg::PHASE_FETCH);
  endtask

  task automatic t_single();
    start(7);
    stat(32'h805);
    panel.press(8, 6);
    stat(32'h805);
    walk(5, 6);
    chk(run, 1'b1);
    stop(15'h6000);
    chk(phase, rhpc_pkg::PHASE_FETCH);
    start(6);
    stat(32'h809);
    stop(15'h1000);
  endtask

  task automatic t_restart();
    apb(1'b1, rhpc_pkg::CTRL_OFFSET, 32'h1);
    panel.press(0, 6);
    @(negedge clock);
    chk(run, 1'b1);
    chk(phase, rhpc_pkg::PHASE_INTF);
    stat(32'h403);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_halt();
    t_phase();
    t_single();
    t_restart();
    test_done();
  end
endmodule
